//--- design/flash_cmd_pkg.sv
// constants and types for the suspend, sleep and identification command block
package flash_cmd_pkg;
	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [7:0] OPC_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_RESUME = 8'h7A;
	localparam logic [7:0] OPC_SLEEP = 8'hB9;
	localparam logic [7:0] OPC_RELEASE = 8'hAB;
	localparam logic [7:0] OPC_MFR_ID = 8'h90;
	localparam logic [7:0] OPC_MFR_ID_DUAL = 8'h92;
	localparam logic [7:0] OPC_MFR_ID_QUAD = 8'h94;
	localparam logic [7:0] OPC_UNIQUE_ID = 8'h4B;
	localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
	localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OPC_SECREG_ERASE = 8'h44;
	localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
	localparam logic [7:0] OPC_QUAD_PAGE_PROG = 8'h32;
	localparam logic [7:0] OPC_SECREG_PROG = 8'h42;
	// ************************************************************
	// frame layout, in serial clocks counted from the first opcode clock
	// ************************************************************
	localparam logic [6:0] OPCODE_BITS = 7'h08;
	localparam logic [6:0] START_RELEASE = 7'h20;
	localparam logic [6:0] START_MFR = 7'h20;
	localparam logic [6:0] START_MFR_DUAL = 7'h18;
	localparam logic [6:0] START_MFR_QUAD = 7'h14;
	localparam logic [6:0] START_UNIQUE = 7'h28;
	localparam logic [6:0] CNT_MAX = 7'h7F;
	localparam logic [6:0] LEN_DEV = 7'h08;
	localparam logic [6:0] LEN_MFR_DEV = 7'h10;
	localparam logic [6:0] LEN_UID = 7'h40;
	localparam logic [1:0] LANE_SH_SINGLE = 2'h0;
	localparam logic [1:0] LANE_SH_DUAL = 2'h1;
	localparam logic [1:0] LANE_SH_QUAD = 2'h2;
	localparam logic [3:0] OE_N_IDLE = 4'hF;
	localparam logic [3:0] OE_N_SINGLE = 4'hD;
	localparam logic [3:0] OE_N_DUAL = 4'hC;
	localparam logic [3:0] OE_N_QUAD = 4'h0;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int SUSPEND_LATENCY_NS = 20000;
	localparam int SLEEP_ENTRY_TIME_NS = 3000;
	localparam int WAKE_DELAY_PLAIN_NS = 3000;
	localparam int WAKE_DELAY_WITH_ID_NS = 1800;
	localparam int RESUME_BUSY_NS = 200;
	// longest times, rounded down, never under one cycle
	localparam logic [12:0] TSUS_CYC = 13'((SUSPEND_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 :
		SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
	localparam logic [12:0] TDP_CYC = 13'((SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
		SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
	localparam logic [12:0] WAKE_DELAY_PLAIN_CYC = 13'((WAKE_DELAY_PLAIN_NS / CLK_PERIOD_NS < 1) ? 1 :
		WAKE_DELAY_PLAIN_NS / CLK_PERIOD_NS);
	localparam logic [12:0] WAKE_DELAY_WITH_ID_CYC = 13'((WAKE_DELAY_WITH_ID_NS / CLK_PERIOD_NS < 1) ? 1 :
		WAKE_DELAY_WITH_ID_NS / CLK_PERIOD_NS);
	localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS / CLK_PERIOD_NS < 1) ? 1 :
		RESUME_BUSY_NS / CLK_PERIOD_NS;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {KIND_NONE, KIND_SECTOR, KIND_BLOCK, KIND_PAGE, KIND_CHIP,
		KIND_OTHER} op_kind_t;
	typedef enum logic [1:0] {SRC_NONE, SRC_DEV, SRC_MFR_DEV, SRC_UID} id_src_t;
endpackage

//--- design/flash_suspend_sleep_id_cmds.sv
// suspend/resume, deep sleep and identification command handling of a serial flash
`timescale 1ns/1ps
module flash_suspend_sleep_id_cmds #(
	parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h14, // arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // arbitrary value
) (
	input wire logic clk_sys, // system clock, 200 MHz
	input wire logic srst, // reset, active high; synchronous in the system domain, asynchronous in the link domain
	input wire logic spi_clk, // serial clock from host
	input wire logic cs_n, // chip select, active low
	input wire logic [3:0] io_in, // data lanes in
	output logic [3:0] io_out, // data lanes out
	output logic [3:0] io_oe_n, // lane output enables, low drives
	input wire logic op_start, // engine starts a self-timed cycle
	input wire flash_cmd_pkg::op_kind_t op_kind, // kind of cycle started
	input wire logic engine_done, // engine finished its cycle
	input wire logic engine_halted, // engine reached a safe pause point
	output logic engine_hold, // ask the engine to pause
	output logic busy, // busy status
	output logic suspend_flag, // suspend status
	output logic power_down, // deep sleep status
	output logic cmd_valid, // one-cycle frame report
	output logic [7:0] cmd_opcode, // opcode of reported frame
	output logic cmd_refused // reported frame was refused
);
	localparam int RES_BOUND = 1;
	// ************************************************************
	// link domain: frame capture on the serial clock
	// ************************************************************
	logic [6:0] cnt_reg;
	logic [7:0] op_reg;
	logic frame_tog_reg;
	logic seen8_reg;
	logic extra_reg;
	logic rel_meta_reg;
	logic rel_sync_reg;
	logic id_meta_reg;
	logic id_sync_reg;
	flash_cmd_pkg::id_src_t src;
	logic [6:0] start;
	logic [6:0] len;
	logic [1:0] lane_sh;
	logic [3:0] oe_pat;
	logic allowed;
	logic [6:0] wrap_end;
	logic [6:0] pos;
	logic [63:0] data_word;
	logic [63:0] shifted;
	logic [3:0] lanes;
	logic [3:0] io_out_reg;
	logic [3:0] io_oe_n_reg;
	logic allow_rel_reg;
	logic allow_id_reg;

	// counter restarts with every frame; select high ends the frame
	always_ff @(posedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			cnt_reg <= 7'h00;
		end else if (cnt_reg < flash_cmd_pkg::OPCODE_BITS) begin
			cnt_reg <= cnt_reg + 7'h01;
		end else if (src != flash_cmd_pkg::SRC_NONE && cnt_reg == wrap_end) begin
			cnt_reg <= start;
		end else if (cnt_reg != flash_cmd_pkg::CNT_MAX) begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end

	// opcode and frame length stay put after select rises for the system side
	always_ff @(posedge spi_clk or posedge srst) begin
		if (srst) begin
			op_reg <= 8'h00;
			frame_tog_reg <= 1'b0;
			seen8_reg <= 1'b0;
			extra_reg <= 1'b0;
		end else begin
			if (cnt_reg < flash_cmd_pkg::OPCODE_BITS) begin
				op_reg <= {op_reg[6:0], io_in[0]};
			end
			if (cnt_reg == 7'h00) begin
				frame_tog_reg <= ~frame_tog_reg;
				seen8_reg <= 1'b0;
				extra_reg <= 1'b0;
			end else if (cnt_reg == flash_cmd_pkg::OPCODE_BITS - 7'h01) begin
				seen8_reg <= 1'b1;
			end else if (cnt_reg >= flash_cmd_pkg::OPCODE_BITS) begin
				extra_reg <= 1'b1;
			end
		end
	end

	// status levels enter the link domain; the serial clock gives eight edges in the opcode
	always_ff @(posedge spi_clk or posedge srst) begin
		if (srst) begin
			rel_meta_reg <= 1'b0;
			rel_sync_reg <= 1'b0;
			id_meta_reg <= 1'b0;
			id_sync_reg <= 1'b0;
		end else begin
			rel_meta_reg <= allow_rel_reg;
			rel_sync_reg <= rel_meta_reg;
			id_meta_reg <= allow_id_reg;
			id_sync_reg <= id_meta_reg;
		end
	end

	always_comb begin
		src = flash_cmd_pkg::SRC_NONE;
		start = flash_cmd_pkg::START_MFR;
		len = flash_cmd_pkg::LEN_MFR_DEV;
		lane_sh = flash_cmd_pkg::LANE_SH_SINGLE;
		oe_pat = flash_cmd_pkg::OE_N_SINGLE;
		allowed = id_sync_reg;
		case (op_reg)
			flash_cmd_pkg::OPC_RELEASE: begin
				src = flash_cmd_pkg::SRC_DEV;
				start = flash_cmd_pkg::START_RELEASE;
				len = flash_cmd_pkg::LEN_DEV;
				allowed = rel_sync_reg;
			end
			flash_cmd_pkg::OPC_MFR_ID: begin
				src = flash_cmd_pkg::SRC_MFR_DEV;
			end
			flash_cmd_pkg::OPC_MFR_ID_DUAL: begin
				src = flash_cmd_pkg::SRC_MFR_DEV;
				start = flash_cmd_pkg::START_MFR_DUAL;
				lane_sh = flash_cmd_pkg::LANE_SH_DUAL;
				oe_pat = flash_cmd_pkg::OE_N_DUAL;
			end
			flash_cmd_pkg::OPC_MFR_ID_QUAD: begin
				src = flash_cmd_pkg::SRC_MFR_DEV;
				start = flash_cmd_pkg::START_MFR_QUAD;
				lane_sh = flash_cmd_pkg::LANE_SH_QUAD;
				oe_pat = flash_cmd_pkg::OE_N_QUAD;
			end
			flash_cmd_pkg::OPC_UNIQUE_ID: begin
				src = flash_cmd_pkg::SRC_UID;
				start = flash_cmd_pkg::START_UNIQUE;
				len = flash_cmd_pkg::LEN_UID;
			end
			default: begin
				src = flash_cmd_pkg::SRC_NONE;
			end
		endcase
	end

	always_comb begin
		case (src)
			flash_cmd_pkg::SRC_DEV: data_word = {DEV_ID, 56'h0};
			flash_cmd_pkg::SRC_MFR_DEV: data_word = {MFR_ID, DEV_ID, 48'h0};
			flash_cmd_pkg::SRC_UID: data_word = UNIQUE_ID;
			default: data_word = 64'h0;
		endcase
	end

	assign wrap_end = 7'(start + (len >> lane_sh) - 7'h01);
	assign pos = 7'((cnt_reg - start) << lane_sh);
	assign shifted = data_word << pos;

	always_comb begin
		lanes = 4'h0;
		case (lane_sh)
			flash_cmd_pkg::LANE_SH_DUAL: lanes = {2'h0, shifted[63:62]};
			flash_cmd_pkg::LANE_SH_QUAD: lanes = shifted[63:60];
			default: lanes = {2'h0, shifted[63], 1'b0};
		endcase
	end

	// lanes turn round on the falling edge, or release at once when select rises, so the host samples a settled bit
	always_ff @(negedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			io_out_reg <= 4'h0;
			io_oe_n_reg <= flash_cmd_pkg::OE_N_IDLE;
		end else if (cnt_reg >= start && cnt_reg >= flash_cmd_pkg::OPCODE_BITS &&
			src != flash_cmd_pkg::SRC_NONE && allowed) begin
			io_out_reg <= lanes;
			io_oe_n_reg <= oe_pat;
		end else begin
			io_out_reg <= 4'h0;
			io_oe_n_reg <= flash_cmd_pkg::OE_N_IDLE;
		end
	end

	assign io_out = io_out_reg;
	assign io_oe_n = io_oe_n_reg;

	// ************************************************************
	// system domain: frame end detection
	// ************************************************************
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic tog_seen_reg;
	logic new_frame;
	logic len8;
	logic busy_reg;
	logic sus_reg;
	logic pd_reg;
	flash_cmd_pkg::op_kind_t kind_reg;
	logic [12:0] halt_cnt_reg;
	logic [12:0] dp_cnt_reg;
	logic [12:0] wake_cnt_reg;
	logic is_erase;
	logic is_prog;
	logic susp_erase;
	logic susp_prog;
	logic refuse;
	logic acc_suspend;
	logic acc_resume;
	logic acc_sleep;
	logic acc_wake;
	logic cmd_valid_reg;
	logic [7:0] cmd_opcode_reg;
	logic cmd_refused_reg;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end else begin
			cs_meta_reg <= cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
		end
	end

	// link words are read only once select has been high for two system edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tog_seen_reg <= 1'b0;
		end else if (cs_sync_reg && !cs_prev_reg) begin
			tog_seen_reg <= frame_tog_reg;
		end
	end

	assign new_frame = cs_sync_reg && !cs_prev_reg && (frame_tog_reg != tog_seen_reg) &&
		seen8_reg;
	assign len8 = !extra_reg;

	// ************************************************************
	// command admission
	// ************************************************************
	assign is_erase = op_reg inside {flash_cmd_pkg::OPC_SECTOR_ERASE,
		flash_cmd_pkg::OPC_BLOCK32_ERASE, flash_cmd_pkg::OPC_BLOCK64_ERASE,
		flash_cmd_pkg::OPC_CHIP_ERASE_A, flash_cmd_pkg::OPC_CHIP_ERASE_B,
		flash_cmd_pkg::OPC_SECREG_ERASE};
	assign is_prog = op_reg inside {flash_cmd_pkg::OPC_PAGE_PROG,
		flash_cmd_pkg::OPC_QUAD_PAGE_PROG, flash_cmd_pkg::OPC_SECREG_PROG};
	assign susp_erase = sus_reg && (kind_reg == flash_cmd_pkg::KIND_SECTOR ||
		kind_reg == flash_cmd_pkg::KIND_BLOCK);
	assign susp_prog = sus_reg && kind_reg == flash_cmd_pkg::KIND_PAGE;

	always_comb begin
		refuse = 1'b0;
		if (wake_cnt_reg != 13'h0000) begin
			refuse = 1'b1;
		end else if (pd_reg && op_reg != flash_cmd_pkg::OPC_RELEASE) begin
			refuse = 1'b1;
		end else if (susp_erase && (is_erase || op_reg == flash_cmd_pkg::OPC_WRITE_STATUS)) begin
			refuse = 1'b1;
		end else if (susp_prog && (is_prog || op_reg == flash_cmd_pkg::OPC_WRITE_STATUS)) begin
			refuse = 1'b1;
		end else if (op_reg == flash_cmd_pkg::OPC_RELEASE && busy_reg) begin
			refuse = 1'b1;
		end
	end

	assign acc_suspend = new_frame && !refuse && len8 && op_reg == flash_cmd_pkg::OPC_SUSPEND &&
		!sus_reg && busy_reg && (kind_reg == flash_cmd_pkg::KIND_SECTOR ||
		kind_reg == flash_cmd_pkg::KIND_BLOCK || kind_reg == flash_cmd_pkg::KIND_PAGE);
	assign acc_resume = new_frame && !refuse && len8 && op_reg == flash_cmd_pkg::OPC_RESUME &&
		sus_reg && !busy_reg;
	assign acc_sleep = new_frame && !refuse && len8 && op_reg == flash_cmd_pkg::OPC_SLEEP &&
		!busy_reg && !pd_reg && dp_cnt_reg == 13'h0000;
	assign acc_wake = new_frame && !refuse && op_reg == flash_cmd_pkg::OPC_RELEASE && pd_reg;

	// ************************************************************
	// busy and suspend
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			busy_reg <= 1'b0;
			kind_reg <= flash_cmd_pkg::KIND_NONE;
		end else if (acc_resume) begin
			busy_reg <= 1'b1;
		end else if (sus_reg && busy_reg &&
			(engine_halted || engine_done || halt_cnt_reg == flash_cmd_pkg::TSUS_CYC - 13'h0001)) begin
			busy_reg <= 1'b0;
		end else if (op_start && !busy_reg && !sus_reg) begin
			busy_reg <= 1'b1;
			kind_reg <= op_kind;
		end else if (busy_reg && engine_done) begin
			busy_reg <= 1'b0;
			kind_reg <= flash_cmd_pkg::KIND_NONE;
		end
	end

	// power loss is a reset, so nothing is left suspended to resume
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sus_reg <= 1'b0;
		end else if (acc_suspend) begin
			sus_reg <= 1'b1;
		end else if (acc_resume) begin
			sus_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || acc_suspend) begin
			halt_cnt_reg <= 13'h0000;
		end else if (sus_reg && busy_reg && halt_cnt_reg != flash_cmd_pkg::TSUS_CYC) begin
			halt_cnt_reg <= halt_cnt_reg + 13'h0001;
		end
	end

	// ************************************************************
	// deep sleep and wake
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dp_cnt_reg <= 13'h0000;
		end else if (acc_sleep) begin
			dp_cnt_reg <= flash_cmd_pkg::TDP_CYC;
		end else if (dp_cnt_reg != 13'h0000) begin
			dp_cnt_reg <= dp_cnt_reg - 13'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wake_cnt_reg <= 13'h0000;
		end else if (acc_wake) begin
			wake_cnt_reg <= len8 ? flash_cmd_pkg::WAKE_DELAY_PLAIN_CYC : flash_cmd_pkg::WAKE_DELAY_WITH_ID_CYC;
		end else if (wake_cnt_reg != 13'h0000) begin
			wake_cnt_reg <= wake_cnt_reg - 13'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pd_reg <= 1'b0;
		end else if (wake_cnt_reg == 13'h0001) begin
			pd_reg <= 1'b0;
		end else if (dp_cnt_reg == 13'h0001) begin
			pd_reg <= 1'b1;
		end
	end

	// ************************************************************
	// status to the link and frame reports
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			allow_rel_reg <= 1'b0;
			allow_id_reg <= 1'b0;
		end else begin
			allow_rel_reg <= !busy_reg && wake_cnt_reg == 13'h0000;
			allow_id_reg <= !busy_reg && !pd_reg && wake_cnt_reg == 13'h0000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cmd_valid_reg <= 1'b0;
			cmd_opcode_reg <= 8'h00;
			cmd_refused_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= new_frame;
			if (new_frame) begin
				cmd_opcode_reg <= op_reg;
				cmd_refused_reg <= refuse;
			end
		end
	end

	assign busy = busy_reg;
	assign suspend_flag = sus_reg;
	assign engine_hold = sus_reg;
	assign power_down = pd_reg;
	assign cmd_valid = cmd_valid_reg;
	assign cmd_opcode = cmd_opcode_reg;
	assign cmd_refused = cmd_refused_reg;

	// ************************************************************
	// checks
	// ************************************************************
	a_suspend_needs_busy: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(sus_reg) |-> $past(busy_reg) && !$past(sus_reg))
		else $error("suspend taken without busy");
	a_no_chip_suspend: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(sus_reg) |-> $past(kind_reg) != flash_cmd_pkg::KIND_CHIP)
		else $error("suspend taken during chip erase");
	a_erase_susp_refuse: assert property (@(posedge clk_sys) disable iff (srst)
		new_frame && susp_erase && is_erase |=> cmd_valid_reg && cmd_refused_reg)
		else $error("erase admitted while erase suspended");
	a_prog_susp_refuse: assert property (@(posedge clk_sys) disable iff (srst)
		new_frame && susp_prog && (is_prog || op_reg == flash_cmd_pkg::OPC_WRITE_STATUS)
		|=> cmd_refused_reg)
		else $error("program admitted while program suspended");
	a_suspend_latency: assert property (@(posedge clk_sys) disable iff (srst)
		sus_reg && busy_reg |-> halt_cnt_reg < flash_cmd_pkg::TSUS_CYC)
		else $error("busy held past suspend latency");
	a_reset_clears: assert property (@(posedge clk_sys) disable iff (srst)
		$past(srst) |-> !sus_reg && !pd_reg && !busy_reg)
		else $error("state survives reset");
	a_resume_busy: assert property (@(posedge clk_sys) disable iff (srst)
		acc_resume |=> ##[0:RES_BOUND] busy_reg && !sus_reg)
		else $error("busy not raised after resume");
	a_resume_ignored: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(sus_reg) |-> !$past(busy_reg))
		else $error("resume taken while busy");
	a_sleep_only_release: assert property (@(posedge clk_sys) disable iff (srst)
		new_frame && pd_reg && op_reg != flash_cmd_pkg::OPC_RELEASE |=> cmd_refused_reg)
		else $error("command admitted while asleep");
	a_wake_blocks: assert property (@(posedge clk_sys) disable iff (srst)
		new_frame && wake_cnt_reg != 13'h0000 |=> cmd_refused_reg && $stable(sus_reg))
		else $error("command admitted during wake delay");
	a_busy_done: assert property (@(posedge clk_sys) disable iff (srst)
		busy_reg && engine_done && !sus_reg && !acc_resume |=> !busy_reg)
		else $error("busy not dropped at completion");
endmodule

//--- verif/flash_suspend_sleep_id_cmds_test.sv
// self-checking bench for the suspend, sleep and identification command block
`timescale 1ns/1ps
module flash_suspend_sleep_id_cmds_test;
	localparam logic [7:0] MFR = 8'hC3; // arbitrary value
	localparam logic [7:0] DEV = 8'h3C; // arbitrary value
	localparam logic [63:0] UID = 64'h0F1E2D3C4B5A6978; // arbitrary value
	logic clk_sys, srst, op_start, engine_done, engine_halted, spi_clk, cs_n;
	logic engine_hold, busy, suspend_flag, power_down, cmd_valid, cmd_refused;
	flash_cmd_pkg::op_kind_t op_kind;
	logic [3:0] io_in, io_out, io_oe_n, drv;
	logic [7:0] cmd_opcode;
	logic [7:0] ops[7];
	logic [7:0] pops[4];
	logic [9:0] exp_q[$];
	logic [9:0] note;
	int err_total, total_checks;
	// device lanes win wherever their enable is low
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv);
	spi_host_model u_host (.spi_clk(spi_clk), .cs_n(cs_n), .drv(drv), .io_out(io_out),
		.io_oe_n(io_oe_n));
	flash_suspend_sleep_id_cmds #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) u_dut (
		.clk_sys(clk_sys), .srst(srst), .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .op_start(op_start), .op_kind(op_kind),
		.engine_done(engine_done), .engine_halted(engine_halted), .engine_hold(engine_hold),
		.busy(busy), .suspend_flag(suspend_flag), .power_down(power_down),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_refused(cmd_refused));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic eng(logic s, logic d, logic h, flash_cmd_pkg::op_kind_t k);
		@(posedge clk_sys);
		op_start <= s;
		engine_done <= d;
		engine_halted <= h;
		op_kind <= k;
		@(posedge clk_sys);
		op_start <= 1'b0;
		engine_done <= 1'b0;
		engine_halted <= 1'b0;
	endtask
	// care set means the refusal bit of the report is compared too
	task automatic send(logic [7:0] op, int n, logic care, logic refd, int start = 999,
		int lanes = 1);
		exp_q.push_back({op, care, refd});
		u_host.frame(op, n, start, lanes);
	endtask
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1) begin
			note = exp_q.pop_front();
			check("opcode", cmd_opcode, note[9:2]);
			if (note[1]) check("refused", cmd_refused, note[0]);
		end
	end
	initial begin
		#300000;
		err_total++;
		stop_test();
	end
	initial begin
		err_total = 0;
		total_checks = 0;
		srst = 1'b1;
		op_start = 1'b0;
		engine_done = 1'b0;
		engine_halted = 1'b0;
		op_kind = flash_cmd_pkg::KIND_NONE;
		ops = '{8'h01, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h44};
		pops = '{8'h01, 8'h02, 8'h32, 8'h42};
		cyc(5);
		srst <= 1'b0;
		cyc(3);
		check("awake", power_down, 0);
		check("sus_rst", suspend_flag, 0);
		send(8'hAB, 64, 1, 0, 32, 1);
		check("dev_id", u_host.got[31:0], {4{DEV}});
		send(8'h90, 64, 1, 0, 32, 1);
		check("mfr_dev", u_host.got[31:0], {2{MFR, DEV}});
		send(8'h92, 40, 1, 0, 24, 2);
		check("dual_id", u_host.got[31:0], {2{MFR, DEV}});
		send(8'h94, 28, 1, 0, 20, 4);
		check("quad_id", u_host.got[31:0], {2{MFR, DEV}});
		send(8'h4B, 104, 1, 0, 40, 1);
		check("uid", u_host.got, UID);
		eng(1, 0, 0, flash_cmd_pkg::KIND_SECTOR);
		cyc(2);
		check("busy_op", busy, 1);
		send(8'h75, 8, 0, 0);
		check("sus_set", suspend_flag, 1);
		check("hold", engine_hold, 1);
		eng(0, 0, 1, flash_cmd_pkg::KIND_NONE);
		cyc(3);
		check("busy_sus", busy, 0);
		foreach (ops[i]) send(ops[i], 32, 1, 1);
		send(8'h7A, 8, 0, 0);
		check("sus_clr", suspend_flag, 0);
		check("busy_res", busy, 1);
		eng(0, 1, 0, flash_cmd_pkg::KIND_NONE);
		cyc(3);
		check("busy_done", busy, 0);
		send(8'h7A, 8, 0, 0);
		check("res_idle", busy, 0);
		cyc(4000);
		eng(1, 0, 0, flash_cmd_pkg::KIND_CHIP);
		send(8'h75, 8, 0, 0);
		check("sus_chip", suspend_flag, 0);
		eng(0, 1, 0, flash_cmd_pkg::KIND_NONE);
		eng(1, 0, 0, flash_cmd_pkg::KIND_OTHER);
		send(8'h75, 8, 0, 0);
		check("sus_other", suspend_flag, 0);
		eng(0, 1, 0, flash_cmd_pkg::KIND_NONE);
		eng(1, 0, 0, flash_cmd_pkg::KIND_PAGE);
		send(8'hAB, 64, 1, 1, 32, 1);
		check("id_busy", u_host.drove, 0);
		check("busy_kept", busy, 1);
		send(8'h75, 8, 0, 0);
		check("sus_page", suspend_flag, 1);
		foreach (pops[i]) send(pops[i], 32, 1, 1);
		@(posedge clk_sys);
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		cyc(3);
		check("sus_lost", suspend_flag, 0);
		send(8'h7A, 8, 0, 0);
		check("res_lost", busy, 0);
		send(8'hB9, 9, 0, 0);
		cyc(800);
		check("sleep_long", power_down, 0);
		send(8'hB9, 8, 0, 0);
		cyc(800);
		check("sleep", power_down, 1);
		send(8'h90, 64, 1, 1, 32, 1);
		check("id_asleep", u_host.drove, 0);
		send(8'hAB, 8, 0, 0);
		cyc(300);
		check("waking", power_down, 1);
		cyc(400);
		check("woke", power_down, 0);
		send(8'hB9, 8, 0, 0);
		cyc(800);
		send(8'hAB, 48, 0, 0, 32, 1);
		check("wake_id", u_host.got[15:0], {2{DEV}});
		cyc(450);
		check("woke_id", power_down, 0);
		check("pending", exp_q.size(), 0);
		stop_test();
	end
endmodule

//--- verif/spi_host_model.sv
// host-side serial controller model that drives frames at the link pins
`timescale 1ns/1ps
module spi_host_model (
	output logic spi_clk, // serial clock, still between frames
	output logic cs_n, // chip select, active low
	output logic [3:0] drv, // lane values from host
	input wire logic [3:0] io_out, // lanes from device
	input wire logic [3:0] io_oe_n // device lane enables, low drives
);
	integer seed;
	logic [63:0] got;
	logic drove;
	initial begin
		seed = 32'h8f654144;
		spi_clk = 1'b0;
		cs_n = 1'b1;
		drv = 4'h0;
		got = 64'h0;
		drove = 1'b0;
	end
	// data from clock index start on is shifted into got, lanes bits per clock
	task automatic frame(logic [7:0] op, int nclk, int start, int lanes);
		got = 64'h0;
		drove = 1'b0;
		cs_n = 1'b0;
		for (int i = 0; i < nclk; i++) begin
			// zero address; mode nibble all ones at the dual and quad mode clocks
			drv = (i < 8) ? {3'($random(seed)), op[7 - i]} :
				((lanes == 2 && (i == 20 || i == 21)) || (lanes == 4 && i == 14)) ? 4'hF :
				4'h0;
			#32;
			spi_clk = 1'b1;
			if (io_oe_n !== 4'hF) drove = 1'b1;
			if (i >= start) got = (lanes == 4) ? {got[59:0], io_out} :
				(lanes == 2) ? {got[61:0], io_out[1:0]} : {got[62:0], io_out[1]};
			#32;
			spi_clk = 1'b0;
		end
		#32;
		cs_n = 1'b1;
		drv = ~drv;
		#200;
	endtask
endmodule
